// ### hw/qspi_pin_pkg.sv
// Overview of operation
// - chip select falling starts, rising ends transaction
// - select low means active, accepting activity
// - deselect enters standby unless operation busy
// - deselected: inputs ignored, outputs high impedance
// - hardware reset honoured while deselected
// - inputs sampled on interface clock rising edge
// - outputs change on interface clock falling edge
// - single mode: data in line0, out line1
// - quad mode: four bidirectional lines by phase; code reads input on line0 only, drives all four lines on output
// - single mode: line2 is write protect input
// - line2 reads high when undriven
// - reset low reinitialises, returns to array read
// - reset low: all four data lines released
// - unconnected reset input reads inactive high
// - ready_busy_n low while internal operation runs
// - every transaction opens with one command byte
// - bytes travel most significant bit first
package qspi_pin_pkg;
    localparam int          CMD_BITS   = 8;
    localparam logic [2:0]  BIT_LAST   = 3'h7;
    localparam logic [3:0]  DQ_NONE    = 4'h0;
    localparam logic [3:0]  DQ_SINGLE  = 4'h2;
    localparam logic [3:0]  DQ_QUAD    = 4'hf;
    localparam logic [1:0]  NIB_LAST   = 2'h1;

    typedef enum {PH_IDLE, PH_CMD, PH_IN, PH_OUT, PH_DONE} phase_t;

    // pin group on the data lines
    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } dq_drive_t;

    // command byte and valid pulse handed to the core
    typedef struct packed {
        logic       valid;
        logic [7:0] cmd;
    } cmd_t;
endpackage

// ### hw/sync2.sv
`timescale 1ns/1ps
// two flop synchroniser for one pin
module sync2 #(
    parameter logic INIT = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic d,
    output logic      q
);
    logic meta;

    // first stage read only by second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= INIT;
            q    <= INIT;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ### hw/qspi_pin_if.sv
`timescale 1ns/1ps
module qspi_pin_if
    import qspi_pin_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire logic                    cs_n_pin,
    input  wire logic                    sck_pin,
    input  wire logic                    hw_reset_n_pin,
    input  wire logic [3:0]              dq_in,
    output qspi_pin_pkg::dq_drive_t      dq_drv,
    output qspi_pin_pkg::cmd_t           cmd_out,
    output logic                         write_protect_n,
    output logic                         active,
    output logic                         ready_busy_n,
    output logic                         core_reset,
    input  wire logic                    quad_mode,
    input  wire logic                    read_phase,
    input  wire logic [7:0]              tx_byte,
    input  wire logic                    op_busy
);
    import qspi_pin_pkg::*;

    // --------------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------------
    logic       cs_s;
    logic       sck_s;
    logic       hrst_s;
    logic [3:0] dq_s;
    logic       sck_d;

    sync2 #(.INIT(1'b1)) u_cs   (.clk(clk), .rst_b(rst_b), .d(cs_n_pin),       .q(cs_s));
    sync2 #(.INIT(1'b0)) u_sck  (.clk(clk), .rst_b(rst_b), .d(sck_pin),        .q(sck_s));
    sync2 #(.INIT(1'b1)) u_hrst (.clk(clk), .rst_b(rst_b), .d(hw_reset_n_pin), .q(hrst_s));

    genvar g;
    for (g = 0; g < 4; g++) begin : g_dq
        sync2 #(.INIT(g == 2)) u_dq (.clk(clk), .rst_b(rst_b), .d(dq_in[g]), .q(dq_s[g]));
    end

    // --------------------------------------------------------------
    // decode of edges and state
    // --------------------------------------------------------------
    logic       cs_d;
    phase_t     phase;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] txsh;
    logic       armed;

    wire sck_rise = sck_s && !sck_d;
    wire sck_fall = !sck_s && sck_d;
    wire cs_fall  = !cs_s && cs_d;
    wire cs_rise  = cs_s && !cs_d;
    // ignore while deselected, reset always honoured
    wire sel      = !cs_s && hrst_s && armed;
    wire cmd_end  = sel && sck_rise && phase == PH_CMD && bit_cnt == BIT_LAST;
    wire [7:0] next_shreg = {shreg[6:0], dq_s[0]};

    // arm only on fresh select after reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            armed <= 1'b0;
        end else if (!hrst_s) begin
            armed <= 1'b0;
        end else if (cs_fall) begin
            armed <= 1'b1;
        end else if (cs_rise) begin
            armed <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_d  <= 1'b1;
            sck_d <= 1'b0;
        end else begin
            cs_d  <= cs_s;
            sck_d <= sck_s;
        end
    end

    // command byte phase, rising edge sampling, msb first
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase   <= PH_IDLE;
            bit_cnt <= 3'h0;
            shreg   <= 8'h00;
        end else if (!sel) begin
            phase   <= (cs_fall && hrst_s) ? PH_CMD : PH_IDLE;
            bit_cnt <= 3'h0;
        end else if (sck_rise) begin
            case (phase)
                PH_CMD: begin
                    shreg   <= next_shreg;
                    bit_cnt <= bit_cnt + 3'h1;
                    if (bit_cnt == BIT_LAST) begin
                        phase <= PH_IN;
                    end
                end
                PH_IN: begin
                    if (read_phase) begin
                        phase <= PH_OUT;
                    end
                end
                PH_OUT:  phase <= PH_OUT;
                PH_IDLE: phase <= PH_CMD;
                default: phase <= PH_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_out <= '0;
        end else begin
            cmd_out.valid <= cmd_end;
            if (cmd_end) begin
                cmd_out.cmd <= next_shreg;
            end
        end
    end

    // --------------------------------------------------------------
    // output launch on falling edge
    // --------------------------------------------------------------
    // falling edge launch, single out on line1, quad nibbles
    wire [7:0] next_txsh = quad_mode ? {txsh[3:0], 4'h0} : {txsh[6:0], 1'b0};
    wire       drive_on  = sel && phase == PH_OUT;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            txsh   <= 8'h00;
            dq_drv <= '0;
        end else if (!drive_on) begin
            dq_drv <= '0;
            txsh   <= tx_byte;
        end else if (sck_fall) begin
            dq_drv.oe  <= quad_mode ? DQ_QUAD : DQ_SINGLE;
            dq_drv.out <= quad_mode ? txsh[7:4] : {2'b00, txsh[7], 1'b0};
            txsh       <= next_txsh;
        end
    end

    // --------------------------------------------------------------
    // status outputs
    // --------------------------------------------------------------
    // write protect level from line2 in single mode
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            write_protect_n <= 1'b1;
            active          <= 1'b0;
            ready_busy_n    <= 1'b1;
            core_reset      <= 1'b1;
        end else begin
            if (!quad_mode && sel) begin
                write_protect_n <= dq_s[2];
            end
            // active while selected, busy keeps it awake
            active       <= sel || op_busy;
            ready_busy_n <= !op_busy;
            core_reset   <= !hrst_s;
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    // command counter must span exactly one byte
    if (CMD_BITS != 8 || int'(BIT_LAST) != CMD_BITS - 1) begin : g_cmd_width
        $error("command bit counter does not match byte width");
    end

    // two deselected cycles with no operation running
    sequence s_idle_two;
        cs_s && !op_busy ##1 cs_s && !op_busy;
    endsequence

    // falling edge launch while driving, per data width
    sequence s_launch_single;
        drive_on && sck_fall && !quad_mode;
    endsequence

    sequence s_launch_quad;
        drive_on && sck_fall && quad_mode;
    endsequence

    a_reset_release: assert property (@(posedge clk) disable iff (!rst_b)
        !hrst_s |=> dq_drv.oe == DQ_NONE) else $error("data lines driven in reset");
    a_desel_release: assert property (@(posedge clk) disable iff (!rst_b)
        cs_s |=> dq_drv.oe == DQ_NONE) else $error("data lines driven while deselected");
    a_busy_pin: assert property (@(posedge clk) disable iff (!rst_b)
        op_busy |=> !ready_busy_n) else $error("busy not shown");
    a_cmd_after: assert property (@(posedge clk) disable iff (!rst_b)
        cmd_end |=> cmd_out.valid && cmd_out.cmd == $past(next_shreg))
        else $error("command byte lost");
    a_no_rearm: assert property (@(posedge clk) disable iff (!rst_b)
        !hrst_s |=> !armed) else $error("armed during reset");
    a_launch_fall: assert property (@(posedge clk) disable iff (!rst_b)
        $changed(dq_drv.out) && $past(drive_on) |-> $past(sck_fall))
        else $error("output changed off falling edge");
    a_standby: assert property (@(posedge clk) disable iff (!rst_b)
        s_idle_two |-> !active) else $error("no standby");
    a_reset_core: assert property (@(posedge clk) disable iff (!rst_b)
        !hrst_s |=> core_reset) else $error("core not reset");
    a_busy_awake: assert property (@(posedge clk) disable iff (!rst_b)
        op_busy |=> active) else $error("standby during operation");
    a_ready_free: assert property (@(posedge clk) disable iff (!rst_b)
        !op_busy |=> ready_busy_n) else $error("busy shown while idle");
    a_single_line: assert property (@(posedge clk) disable iff (!rst_b)
        s_launch_single |=> dq_drv.oe == DQ_SINGLE) else $error("single output not on line1");
    a_quad_lines: assert property (@(posedge clk) disable iff (!rst_b)
        s_launch_quad |=> dq_drv.oe == DQ_QUAD) else $error("quad output not on four lines");
    a_wp_sample: assert property (@(posedge clk) disable iff (!rst_b)
        sel && !quad_mode |=> write_protect_n == $past(dq_s[2]))
        else $error("write protect level not followed");
    a_cmd_last: assert property (@(posedge clk) disable iff (!rst_b)
        cmd_end |=> cmd_out.cmd[0] == $past(dq_s[0])) else $error("last command bit misplaced");
endmodule

// ### verif/qspi_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// host controller model driving the pins
// ----------------------------------------
module qspi_host_model (
    input  wire logic       clk,
    output logic            cs_n,
    output logic            sck,
    output logic [3:0]      dq_o,
    output logic [3:0]      dq_oe,
    input  wire logic [3:0] dq_i
);
    logic idle;

    // pins start deselected and released
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        idle = 1'b0;
        dq_o = 4'h0;
        dq_oe = 4'h0;
    end

    // one clock phase, four system clocks long
    task automatic ph(input logic lvl);
        sck = lvl;
        repeat (4) @(negedge clk);
    endtask

    // select with idle level and driven protect
    task automatic start(input logic m3, input logic wp);
        idle = m3;
        sck = m3;
        dq_o = {1'b0, wp, 2'b00};
        dq_oe = 4'h5;
        repeat (2) @(negedge clk);
        cs_n = 1'b0;
    endtask

    // byte on line0, msb first, changed while low
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            dq_o[0] = b[i];
            ph(1'b0);
            ph(1'b1);
        end
    endtask

    // turnaround rise, then sample at each rise
    task automatic recv(input logic quad, output logic [7:0] b);
        dq_oe = 4'h0;
        b = 8'h00;
        ph(1'b0);
        ph(1'b1);
        for (int i = 0; i < (quad ? 2 : 8); i++) begin
            ph(1'b0);
            b = quad ? {b[3:0], dq_i} : {b[6:0], dq_i[1]};
            ph(1'b1);
        end
    endtask

    task automatic stop();
        sck = idle;
        repeat (2) @(negedge clk);
        cs_n = 1'b1;
        dq_oe = 4'h0;
        repeat (8) @(negedge clk);
    endtask
endmodule

// ### verif/quad_serial_flash_pin_interface_tb_top.sv
`timescale 1ns/1ps
module quad_serial_flash_pin_interface_tb_top;
    import qspi_pin_pkg::*;
    logic       clk, rst_b, hw_reset_n, quad_mode, read_phase, op_busy, cs_n, sck;
    logic       write_protect_n, active, ready_busy_n, core_reset, wp;
    logic [3:0] h_o, h_oe, dq_w;
    logic [3:0] pat = 4'h0;
    logic [7:0] tx_byte, rx, c;
    dq_drive_t  dq_drv;
    cmd_t       cmd_out;
    int         bad_count, n_checks, seed;
    logic [7:0] exp_q[$];

    qspi_pin_if u_qspi_pin_if (.clk(clk), .rst_b(rst_b), .cs_n_pin(cs_n), .sck_pin(sck),
        .hw_reset_n_pin(hw_reset_n), .dq_in(dq_w), .dq_drv(dq_drv), .cmd_out(cmd_out),
        .write_protect_n(write_protect_n), .active(active), .ready_busy_n(ready_busy_n),
        .core_reset(core_reset), .quad_mode(quad_mode), .read_phase(read_phase),
        .tx_byte(tx_byte), .op_busy(op_busy));
    qspi_host_model u_qspi_host_model (.clk(clk), .cs_n(cs_n), .sck(sck), .dq_o(h_o),
        .dq_oe(h_oe), .dq_i(dq_w));

    // wire level: line2 pulled high, others toggle when released
    assign dq_w = (dq_drv.oe & dq_drv.out) | (~dq_drv.oe & h_oe & h_o)
                | (~dq_drv.oe & ~h_oe & {pat[3], 1'b1, pat[1:0]});

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(negedge clk) pat <= ~pat;

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // command model: every pulse must match the next queued byte
    always @(negedge clk) if (cmd_out.valid === 1'b1) begin
        if (exp_q.size() == 0) begin
            check("cmd unexpected", 8'h00, 8'h01);
        end else begin
            check("cmd", exp_q.pop_front(), cmd_out.cmd);
        end
    end

    // one framed command, read back with the given width
    task automatic frame_read(input logic q);
        c = 8'($random(seed));
        wp = 1'($random(seed));
        tx_byte = 8'($random(seed));
        quad_mode = q;
        exp_q.push_back(c);
        u_qspi_host_model.start(1'($random(seed)), wp);
        u_qspi_host_model.send(c);
        if (!q) check("wp", {7'h0, wp}, {7'h0, write_protect_n});
        read_phase = 1'b1;
        u_qspi_host_model.recv(q, rx);
        read_phase = 1'b0;
        check("rx", tx_byte, rx);
        check("oe", {4'h0, q ? DQ_QUAD : DQ_SINGLE}, {4'h0, dq_drv.oe});
    endtask

    // test sequence
    initial begin
        {rst_b, quad_mode, read_phase, op_busy, tx_byte} = '0;
        hw_reset_n = 1'b1;
        seed = 32'hfb9b;
        repeat (16) @(negedge clk);
        check("reset", 8'h06, {dq_drv.oe, cmd_out.valid, ready_busy_n, core_reset, active});
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 4; i++) begin
            c = 8'($random(seed));
            exp_q.push_back(c);
            u_qspi_host_model.start(1'(i), 1'b1);
            u_qspi_host_model.send(c);
            u_qspi_host_model.stop();
        end
        $display("test commands done");
        for (int q = 0; q < 2; q++) begin
            frame_read(1'(q));
            u_qspi_host_model.stop();
            check("oe off", 8'h00, {4'h0, dq_drv.oe});
        end
        $display("test reads done");
        op_busy = 1'b1;
        repeat (4) @(negedge clk);
        check("busy", 8'h02, {6'h0, active, ready_busy_n});
        op_busy = 1'b0;
        repeat (4) @(negedge clk);
        check("idle", 8'h01, {6'h0, active, ready_busy_n});
        u_qspi_host_model.send(8'($random(seed)));
        $display("test deselected done");
        frame_read(1'b0);
        hw_reset_n = 1'b0;
        repeat (4) @(negedge clk);
        check("hw reset", 8'h10, {3'h0, core_reset, dq_drv.oe});
        hw_reset_n = 1'b1;
        repeat (4) @(negedge clk);
        repeat (2) u_qspi_host_model.send(~c);
        u_qspi_host_model.stop();
        hw_reset_n = 1'b0;
        repeat (4) @(negedge clk);
        check("reset deselected", 8'h01, {7'h0, core_reset});
        hw_reset_n = 1'b1;
        repeat (4) @(negedge clk);
        frame_read(1'b1);
        u_qspi_host_model.stop();
        check("pending", 8'h00, 8'(exp_q.size()));
        $display("test hardware reset done");
        report_and_stop();
    end

    // watchdog: about ten times the expected 1036 clocks
    initial begin
        #400000;
        bad_count++;
        report_and_stop();
    end
endmodule
